// file: design/multi_input_wakeup_unit.sv
// Eight-channel wake-up and interrupt source unit, device end.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Eight channels, selectable edge, raise requests.
// - Active channel raises the wake interrupt line.
// - Wake request offered to power management.
// - Source bit picks pin or timer pulse.
// - Channels one to seven use own pins.
// - Polarity bit clear rising, set falling.
// - Reset clears polarity: all rising edges.
// - Every detected edge of the selected polarity latches its pending flag.
// - Output only when pending and enabled.
// - Reset clears enable register.
// - Pending bits report channels, reset clears.
// - Pending writes set ones, ignore zeros.
// - Clear register ones clear pending flags.
// - Software never read-modify-writes clear register.
// - Detection keeps working in every mode.
// - Wake restarts clocks; interrupt resumes code.
// - Software writes zero to reserved bits.
// - Setup order: disable, inputs, polarity, clear, enable.
// - Polarity change: disable, write, clear, enable.
module multi_input_wakeup_unit #(
    parameter int CHANNELS = wake_pkg::NUM_CHANNELS
) (
    input  wire logic                ref_clk,
    input  wire logic                rst,
    input  wire logic [CHANNELS-1:0] wake_input_pin,
    input  wire logic                timer_expiry_pulse,
    wake_if.device                   bus
);
    import wake_pkg::*;

    if (CHANNELS < 1 || CHANNELS > DATA_W) begin : g_bad_channels
        $error("CHANNELS must lie between 1 and the register width.");
    end

    logic [CHANNELS-1:0] edge_polarity_select_r;
    logic [CHANNELS-1:0] channel_enable_mask_r;
    logic                ch0_source_bit_r;
    logic [CHANNELS-1:0] wake_pending_flags_r;
    logic [CHANNELS-1:0] wake_pending_flags_nxt;
    logic [CHANNELS-1:0] trigger_src;
    logic [CHANNELS-1:0] rise;
    logic [CHANNELS-1:0] fall;
    logic [CHANNELS-1:0] hw_set;
    logic [CHANNELS-1:0] sw_set;
    logic [CHANNELS-1:0] sw_clr;
    logic [DATA_W-1:0]   rdata_nxt;
    logic [DATA_W-1:0]   rdata_r;
    logic                ack_r;
    logic                wake_req_r;
    logic                irq_r;
    logic                active_any;

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
        hit = (addr == target);
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [CHANNELS-1:0] value);
        logic [DATA_W-1:0] result;
        result = '0;
        result[CHANNELS-1:0] = value;
        widen = result;
    endfunction

    // Channel sources and edge detectors.
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
            if (ch == 0) begin : g_src0
                assign trigger_src[ch] = ch0_source_bit_r ? timer_expiry_pulse : wake_input_pin[ch];
            end else begin : g_srcn
                assign trigger_src[ch] = wake_input_pin[ch];
            end

            edge_sync u_edge_sync (
                .ref_clk  (ref_clk),
                .rst      (rst),
                .async_in (trigger_src[ch]),
                .rise     (rise[ch]),
                .fall     (fall[ch])
            );
        end
    endgenerate

    assign hw_set = (rise & ~edge_polarity_select_r) | (fall & edge_polarity_select_r);

    assign sw_set = (bus.reg_wr && hit(bus.reg_addr, ADDR_PENDING_FLAGS)) ? bus.reg_wdata[CHANNELS-1:0] : '0;
    assign sw_clr = (bus.reg_wr && hit(bus.reg_addr, ADDR_PENDING_CLEAR)) ? bus.reg_wdata[CHANNELS-1:0] : '0;

    assign wake_pending_flags_nxt = ((wake_pending_flags_r | sw_set) & ~sw_clr) | hw_set;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_pending_flags_r <= RESET_PENDING_FLAGS[CHANNELS-1:0];
        end else begin
            wake_pending_flags_r <= wake_pending_flags_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            edge_polarity_select_r <= RESET_EDGE_POLARITY[CHANNELS-1:0];
        end else if (bus.reg_wr && hit(bus.reg_addr, ADDR_EDGE_POLARITY)) begin
            edge_polarity_select_r <= bus.reg_wdata[CHANNELS-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            channel_enable_mask_r <= RESET_ENABLE_MASK[CHANNELS-1:0];
        end else if (bus.reg_wr && hit(bus.reg_addr, ADDR_ENABLE_MASK)) begin
            channel_enable_mask_r <= bus.reg_wdata[CHANNELS-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ch0_source_bit_r <= RESET_CH0_SOURCE[CH0_SOURCE_BIT];
        end else if (bus.reg_wr && hit(bus.reg_addr, ADDR_CH0_SOURCE)) begin
            ch0_source_bit_r <= bus.reg_wdata[CH0_SOURCE_BIT];
        end
    end

    // Read data mux; the clear register reads back as a fixed fill value.
    always_comb begin
        rdata_nxt = READ_FILL;
        if (hit(bus.reg_addr, ADDR_EDGE_POLARITY)) begin
            rdata_nxt = widen(edge_polarity_select_r);
        end else if (hit(bus.reg_addr, ADDR_ENABLE_MASK)) begin
            rdata_nxt = widen(channel_enable_mask_r);
        end else if (hit(bus.reg_addr, ADDR_CH0_SOURCE)) begin
            rdata_nxt = CH0_SOURCE_MASK & {DATA_W{ch0_source_bit_r}};
        end else if (hit(bus.reg_addr, ADDR_PENDING_FLAGS)) begin
            rdata_nxt = widen(wake_pending_flags_r);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= '0;
            ack_r   <= 1'b0;
        end else begin
            ack_r <= bus.reg_wr | bus.reg_rd;
            if (bus.reg_rd) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign active_any = |(wake_pending_flags_r & channel_enable_mask_r);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_req_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            wake_req_r <= active_any;
            irq_r      <= active_any;
        end
    end

    assign bus.reg_rdata = rdata_r;
    assign bus.reg_ack   = ack_r;
    assign bus.wake_req  = wake_req_r;
    assign bus.wake_interrupt_line = irq_r;

endmodule : multi_input_wakeup_unit

`default_nettype wire

// file: design/wake_pkg.sv
// Shared constants for the wake-up unit and its host end.
package wake_pkg;

    localparam int DATA_W       = 8;
    localparam int ADDR_W       = 3;
    localparam int NUM_CHANNELS = 8;

    // Register indices on the register port.
    localparam logic [ADDR_W-1:0] ADDR_EDGE_POLARITY = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_ENABLE_MASK   = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CH0_SOURCE    = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_PENDING_FLAGS = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_PENDING_CLEAR = 3'h4;

    // Reset values.
    localparam logic [DATA_W-1:0] RESET_EDGE_POLARITY = 8'h00;
    localparam logic [DATA_W-1:0] RESET_ENABLE_MASK   = 8'h00;
    localparam logic [DATA_W-1:0] RESET_CH0_SOURCE    = 8'h00;
    localparam logic [DATA_W-1:0] RESET_PENDING_FLAGS = 8'h00;

    // Field layout of the channel-0 source select register.
    localparam int                CH0_SOURCE_BIT    = 0;
    localparam logic [DATA_W-1:0] CH0_SOURCE_MASK   = 8'h01;

    // Value returned for the write-only clear register and unmapped indices.
    localparam logic [DATA_W-1:0] READ_FILL         = 8'h00;

    // Number of flip-flops an outside input passes.
    localparam int SYNC_STAGES = 3;

endpackage : wake_pkg

// file: design/wake_if.sv
// Register port and request lines between the wake-up unit and its host.
`timescale 1ns/100ps
`default_nettype none

interface wake_if;
    import wake_pkg::*;

    logic [ADDR_W-1:0] reg_addr;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic              reg_ack;
    logic              wake_req;
    logic              wake_interrupt_line;

    modport device (
        input  reg_addr,
        input  reg_wr,
        input  reg_rd,
        input  reg_wdata,
        output reg_rdata,
        output reg_ack,
        output wake_req,
        output wake_interrupt_line
    );

    modport host (
        output reg_addr,
        output reg_wr,
        output reg_rd,
        output reg_wdata,
        input  reg_rdata,
        input  reg_ack,
        input  wake_req,
        input  wake_interrupt_line
    );

endinterface : wake_if

`default_nettype wire

// file: design/edge_sync.sv
// Three-stage input synchroniser with settled-level edge detection.
`timescale 1ns/100ps
`default_nettype none

module edge_sync (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output logic      rise,
    output logic      fall
);
    import wake_pkg::*;

    logic [SYNC_STAGES-1:0] sync_r;
    logic [SYNC_STAGES-1:0] fill_r;
    logic                   settled_r;
    logic                   primed_r;
    logic                   agree;
    logic                   last_stage;

    // The first stage only feeds the second.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync_r <= '0;
        end else begin
            sync_r <= {sync_r[SYNC_STAGES-2:0], async_in};
        end
    end

    // Marks the stages that hold real pin samples, so a cleared stage is never taken as the pin level.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fill_r <= '0;
        end else begin
            fill_r <= {fill_r[SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign last_stage = sync_r[SYNC_STAGES-1];
    assign agree      = (sync_r[SYNC_STAGES-2] == last_stage);

    // The first settled pin level after reset is taken as the baseline, not an edge.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            settled_r <= 1'b0;
            primed_r  <= 1'b0;
        end else if (agree && fill_r[SYNC_STAGES-1]) begin
            settled_r <= last_stage;
            primed_r  <= 1'b1;
        end
    end

    assign rise = primed_r & agree & last_stage & ~settled_r;
    assign fall = primed_r & agree & ~last_stage & settled_r;

endmodule : edge_sync

`default_nettype wire

// file: design/wake_host.sv
// Host end: turns CPU register commands into register-port cycles.
`timescale 1ns/100ps
`default_nettype none

module wake_host (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        cmd_valid,
    input  wire logic                        cmd_write,
    input  wire logic [wake_pkg::ADDR_W-1:0] cmd_addr,
    input  wire logic [wake_pkg::DATA_W-1:0] cmd_wdata,
    output logic                             cmd_ready,
    output logic                             rsp_valid,
    output logic [wake_pkg::DATA_W-1:0]      rsp_data,
    output logic                             wake_out,
    output logic                             irq_out,
    wake_if.host                             bus
);
    import wake_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } host_state_e;

    host_state_e       state_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r;
    logic              wr_r;
    logic              rd_r;
    logic              rsp_valid_r;
    logic [DATA_W-1:0] rsp_data_r;
    logic              take;
    logic [DATA_W-1:0] wdata_clean;

    assign cmd_ready = (state_r == ST_IDLE);
    assign take      = cmd_valid & cmd_ready;

    assign wdata_clean = (cmd_addr == ADDR_CH0_SOURCE) ? (cmd_wdata & CH0_SOURCE_MASK) : cmd_wdata;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (take) begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (bus.reg_ack) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Register-port strobes last exactly one cycle.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            addr_r  <= '0;
            wdata_r <= '0;
            wr_r    <= 1'b0;
            rd_r    <= 1'b0;
        end else begin
            wr_r <= take & cmd_write;
            rd_r <= take & ~cmd_write;
            if (take) begin
                addr_r  <= cmd_addr;
                wdata_r <= wdata_clean;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rsp_valid_r <= 1'b0;
            rsp_data_r  <= '0;
        end else begin
            rsp_valid_r <= (state_r == ST_WAIT) & bus.reg_ack;
            if ((state_r == ST_WAIT) && bus.reg_ack) begin
                rsp_data_r <= (addr_r == ADDR_PENDING_CLEAR) ? READ_FILL : bus.reg_rdata;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wake_out <= 1'b0;
            irq_out  <= 1'b0;
        end else begin
            wake_out <= bus.wake_req;
            irq_out  <= bus.wake_interrupt_line;
        end
    end

    assign bus.reg_addr  = addr_r;
    assign bus.reg_wdata = wdata_r;
    assign bus.reg_wr    = wr_r;
    assign bus.reg_rd    = rd_r;
    assign rsp_valid     = rsp_valid_r;
    assign rsp_data      = rsp_data_r;

endmodule : wake_host

`default_nettype wire

// file: bench/wake_sva.sv
// Assertion checker for the register port and request lines of the wake-up unit.
`timescale 1ns/100ps
`default_nettype none

module wake_sva (
    input wire logic                        ref_clk,
    input wire logic                        rst,
    input wire logic [wake_pkg::ADDR_W-1:0] reg_addr,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [wake_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [wake_pkg::DATA_W-1:0] reg_rdata,
    input wire logic                        reg_ack,
    input wire logic                        wake_req,
    input wire logic                        wake_interrupt_line
);
    import wake_pkg::*;

    logic [DATA_W-1:0] pol_r;
    logic [DATA_W-1:0] en_r;
    logic [DATA_W-1:0] src_r;

    // Shadow copies of the read/write registers, built from the writes seen on the port.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pol_r <= 8'h00;
            en_r  <= 8'h00;
            src_r <= 8'h00;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_EDGE_POLARITY) pol_r <= reg_wdata;
            if (reg_addr == ADDR_ENABLE_MASK) en_r <= reg_wdata;
            if (reg_addr == ADDR_CH0_SOURCE) src_r <= reg_wdata & 8'h01;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_ack_follows; (reg_wr || reg_rd) |=> reg_ack; endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("request without acknowledge");
    property p_ack_cause; reg_ack |-> ($past(reg_wr) || $past(reg_rd)); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");
    property p_irq_matches; wake_interrupt_line == wake_req; endproperty
    a_irq_matches: assert property (p_irq_matches) else $error("interrupt and wake lines differ");
    property p_pol_read; reg_rd && reg_addr == ADDR_EDGE_POLARITY |=> reg_rdata == pol_r; endproperty
    a_pol_read: assert property (p_pol_read) else $error("polarity readback wrong");
    property p_en_read; reg_rd && reg_addr == ADDR_ENABLE_MASK |=> reg_rdata == en_r; endproperty
    a_en_read: assert property (p_en_read) else $error("enable readback wrong");
    property p_src_read; reg_rd && reg_addr == ADDR_CH0_SOURCE |=> reg_rdata == src_r; endproperty
    a_src_read: assert property (p_src_read) else $error("source readback wrong");
    property p_clear_read; reg_rd && reg_addr == ADDR_PENDING_CLEAR |=> reg_rdata == 8'h00; endproperty
    a_clear_read: assert property (p_clear_read) else $error("clear register read not zero");
    property p_unmapped; reg_rd && reg_addr > ADDR_PENDING_CLEAR |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_wake_needs_en; wake_req |-> $past(en_r) != 8'h00; endproperty
    a_wake_needs_en: assert property (p_wake_needs_en) else $error("wake request with no channel enabled");
    property p_en_off_quiet; reg_wr && reg_addr == ADDR_ENABLE_MASK && reg_wdata == 8'h00 |=> ##1 !wake_req; endproperty
    a_en_off_quiet: assert property (p_en_off_quiet) else $error("wake request after all channels disabled");

endmodule // wake_sva

`default_nettype wire

// file: bench/tb_multi_input_wakeup_unit.sv
// Self-checking testbench joining the wake-up unit and its host end.
`timescale 1ns/100ps
`default_nettype none

module tb_multi_input_wakeup_unit;
    import wake_pkg::*;

    logic              ref_clk;
    logic              rst;
    logic [7:0]        pins;
    logic              timer;
    logic              cmd_valid;
    logic              cmd_write;
    logic [ADDR_W-1:0] cmd_addr;
    logic [DATA_W-1:0] cmd_wdata;
    logic              cmd_ready;
    logic              rsp_valid;
    logic [DATA_W-1:0] rsp_data;
    logic              wake_out;
    logic              irq_out;
    int                err_count = 0;
    int                n_tests = 0;

    wake_if link ();

    multi_input_wakeup_unit #(.CHANNELS(8)) i_multi_input_wakeup_unit (.ref_clk(ref_clk), .rst(rst),
        .wake_input_pin(pins), .timer_expiry_pulse(timer), .bus(link));

    wake_host i_wake_host (.ref_clk(ref_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_data(rsp_data), .wake_out(wake_out), .irq_out(irq_out), .bus(link));

    wake_sva i_wake_sva (.ref_clk(ref_clk), .rst(rst), .reg_addr(link.reg_addr), .reg_wr(link.reg_wr),
        .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata), .reg_ack(link.reg_ack),
        .wake_req(link.wake_req), .wake_interrupt_line(link.wake_interrupt_line));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic give_verdict();
        if (err_count == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One host command; waits a bounded time for the response pulse.
    task automatic do_cmd(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr  <= a;
        cmd_wdata <= d;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        @(negedge ref_clk);
        chk({7'h00, cmd_ready}, 8'h00);
        n = 1;
        while (rsp_valid !== 1'b1 && n < 10) begin
            @(negedge ref_clk);
            n++;
        end
        if (n == 10) chk(8'hEE, 8'h00);
        chk({7'h00, cmd_ready}, 8'h01);
        q = rsp_data;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        do_cmd(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] q;
        do_cmd(1'b0, a, 8'h00, q);
        chk(q, exp);
    endtask

    // Pending settles four edges after a pin change; eight leaves margin.
    task automatic set_pins(input logic [7:0] v);
        @(posedge ref_clk);
        pins <= v;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic pulse_timer();
        @(posedge ref_clk);
        timer <= 1'b1;
        repeat (4) @(posedge ref_clk);
        timer <= 1'b0;
        repeat (8) @(posedge ref_clk);
    endtask

    task automatic chk_req(input logic e);
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({6'h00, wake_out, irq_out}, {6'h00, e, e});
    endtask

    task automatic t_reset();
        for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
        chk_req(1'b0);
    endtask

    task automatic t_regs();
        wr(ADDR_EDGE_POLARITY, 8'hA5);
        rd(ADDR_EDGE_POLARITY, 8'hA5);
        wr(ADDR_ENABLE_MASK, 8'h5A);
        rd(ADDR_ENABLE_MASK, 8'h5A);
        wr(ADDR_CH0_SOURCE, 8'hFF);
        rd(ADDR_CH0_SOURCE, 8'h01);
        rd(ADDR_PENDING_CLEAR, 8'h00);
        wr(ADDR_ENABLE_MASK, 8'h00);
        wr(ADDR_EDGE_POLARITY, 8'h00);
        wr(ADDR_CH0_SOURCE, 8'h00);
    endtask

    task automatic t_channels();
        wr(ADDR_ENABLE_MASK, 8'h00);
        wr(ADDR_EDGE_POLARITY, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_PENDING_CLEAR, 8'hFF);
            set_pins(8'h01 << i);
            rd(ADDR_PENDING_FLAGS, 8'h01 << i);
            set_pins(8'h00);
            rd(ADDR_PENDING_FLAGS, 8'h01 << i);
        end
        chk_req(1'b0);
        wr(ADDR_ENABLE_MASK, 8'hFF);
        chk_req(1'b1);
        wr(ADDR_PENDING_CLEAR, 8'hFF);
        chk_req(1'b0);
        wr(ADDR_ENABLE_MASK, 8'h00);
    endtask

    task automatic t_falling();
        wr(ADDR_EDGE_POLARITY, 8'hFF);
        wr(ADDR_PENDING_CLEAR, 8'hFF);
        set_pins(8'hFF);
        rd(ADDR_PENDING_FLAGS, 8'h00);
        set_pins(8'h00);
        rd(ADDR_PENDING_FLAGS, 8'hFF);
        wr(ADDR_EDGE_POLARITY, 8'h00);
        wr(ADDR_PENDING_CLEAR, 8'hFF);
    endtask

    task automatic t_set_clear();
        wr(ADDR_PENDING_FLAGS, 8'h81);
        rd(ADDR_PENDING_FLAGS, 8'h81);
        wr(ADDR_PENDING_FLAGS, 8'h00);
        rd(ADDR_PENDING_FLAGS, 8'h81);
        wr(ADDR_PENDING_CLEAR, 8'h01);
        rd(ADDR_PENDING_FLAGS, 8'h80);
        wr(ADDR_ENABLE_MASK, 8'h01);
        chk_req(1'b0);
        wr(ADDR_ENABLE_MASK, 8'h80);
        chk_req(1'b1);
        wr(ADDR_PENDING_CLEAR, 8'h80);
        chk_req(1'b0);
        wr(ADDR_ENABLE_MASK, 8'h00);
        // The clear write lands on the same edge as the detected rise of pin 2.
        @(posedge ref_clk);
        pins <= 8'h04;
        @(posedge ref_clk);
        wr(ADDR_PENDING_CLEAR, 8'h04);
        rd(ADDR_PENDING_FLAGS, 8'h04);
        set_pins(8'h00);
        wr(ADDR_PENDING_CLEAR, 8'hFF);
    endtask

    task automatic t_source();
        wr(ADDR_CH0_SOURCE, 8'h01);
        wr(ADDR_PENDING_CLEAR, 8'hFF);
        set_pins(8'h01);
        rd(ADDR_PENDING_FLAGS, 8'h00);
        pulse_timer();
        rd(ADDR_PENDING_FLAGS, 8'h01);
        set_pins(8'h03);
        rd(ADDR_PENDING_FLAGS, 8'h03);
        set_pins(8'h00);
        wr(ADDR_CH0_SOURCE, 8'h00);
        wr(ADDR_PENDING_CLEAR, 8'hFF);
        pulse_timer();
        rd(ADDR_PENDING_FLAGS, 8'h00);
    endtask

    // Reset in mid-run with every register loaded and all pins high.
    task automatic t_mid_reset();
        wr(ADDR_EDGE_POLARITY, 8'hFF);
        wr(ADDR_ENABLE_MASK, 8'hFF);
        wr(ADDR_CH0_SOURCE, 8'h01);
        wr(ADDR_PENDING_FLAGS, 8'hFF);
        set_pins(8'hFF);
        chk_req(1'b1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        rd(ADDR_PENDING_FLAGS, 8'h00);
        set_pins(8'h00);
        rd(ADDR_PENDING_FLAGS, 8'h00);
    endtask

    initial begin
        rst       = 1'b1;
        pins      = 8'h00;
        timer     = 1'b0;
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_addr  = 3'h0;
        cmd_wdata = 8'h00;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_reset();
        t_regs();
        t_channels();
        t_falling();
        t_set_clear();
        t_source();
        t_mid_reset();
        give_verdict();
    end

    // The sequence needs well under a thousand cycles; this cuts a hang short.
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end

endmodule // tb_multi_input_wakeup_unit

`default_nettype wire
